/* File: sra_slave.sv */
// sra_slave: serial slave giving an outside master access to 32-bit registers
// assumes sck, ss_n, mosi come from pins; register file and commands sit on core_clk
`timescale 1ns/1ps
module sra_slave #(
	parameter logic [31:0] fw_revision_default = 32'h00000000
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	output logic rd_req,
	output logic [7:0] rd_addr,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic [31:0] fw_revision,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic wr_cmd,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic gyro_zero_start
);
	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] ss_s;
		logic [2:0] mosi_s;
		logic sck_f;
		logic ss_n_f;
		logic mosi_f;
		sra_pkg::sra_phase_type phase;
		logic [2:0] bitcnt;
		logic [1:0] idx;
		logic [7:0] rx;
		logic [7:0] addr;
		logic [31:0] word;
		logic [31:0] tx_word;
		logic miso;
		logic miso_oe;
		logic rd_req;
		logic pend;
		logic [sra_pkg::entry_width-1:0] pend_entry;
		logic gyro;
	} sra_state_type;
	sra_state_type st;
	sra_state_type next_st;
	logic rise;
	logic fall;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic [31:0] wr_word;
	logic buf_ready;
	logic [sra_pkg::entry_width-1:0] buf_out;
	// ----------------------------------------
	// write and command buffer
	// ----------------------------------------
	sra_buffer #(
		.width(sra_pkg::entry_width)
	) u_buf (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.in_valid(st.pend),
		.in_ready(buf_ready),
		.in_data(st.pend_entry),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(buf_out)
	);
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.rd_req = 1'b0;
		next_st.gyro = 1'b0;
		// three-stage pin synchronisers, change taken when stages two and three agree
		next_st.sck_s = {st.sck_s[1:0], sck};
		next_st.ss_s = {st.ss_s[1:0], ss_n};
		next_st.mosi_s = {st.mosi_s[1:0], mosi};
		if (st.sck_s[1] == st.sck_s[2]) begin
			next_st.sck_f = st.sck_s[2];
		end
		if (st.ss_s[1] == st.ss_s[2]) begin
			next_st.ss_n_f = st.ss_s[2];
		end
		if (st.mosi_s[1] == st.mosi_s[2]) begin
			next_st.mosi_f = st.mosi_s[2];
		end
		rise = !st.sck_f && (st.sck_s[1] == st.sck_s[2]) && st.sck_s[2] && !st.ss_n_f;
		fall = st.sck_f && (st.sck_s[1] == st.sck_s[2]) && !st.sck_s[2] && !st.ss_n_f;
		rx_byte = {st.rx[6:0], st.mosi_f};
		byte_done = rise && (st.bitcnt == sra_pkg::last_bit);
		tx_byte = st.tx_word[8*(3-st.idx) +: 8];
		wr_word = {st.word[23:0], rx_byte};
		// byte msb ready before first rising edge
		if (st.phase != sra_pkg::ph_rdata && st.phase != sra_pkg::ph_wdata) begin
			next_st.miso = 1'b0;
		end else if (st.bitcnt == 3'h0) begin
			next_st.miso = tx_byte[7];
		end else if (fall) begin
			next_st.miso = tx_byte[3'h7 - st.bitcnt];
		end
		next_st.miso_oe = !st.ss_n_f;
		if (st.pend && buf_ready) begin
			next_st.pend = 1'b0;
		end
		if (rd_valid && st.phase == sra_pkg::ph_rdata) begin
			next_st.tx_word = rd_data;
		end
		if (rise) begin
			next_st.rx = rx_byte;
			next_st.bitcnt = st.bitcnt + 3'h1;
		end
		if (byte_done) begin
			case (st.phase)
				sra_pkg::ph_op: begin
					if (rx_byte == sra_pkg::op_read) begin
						next_st.phase = sra_pkg::ph_addr;
						next_st.word = 32'h00000000;
					end else if (rx_byte == sra_pkg::op_write) begin
						next_st.phase = sra_pkg::ph_addr;
						next_st.word = 32'h00000001;
					end else begin
						next_st.phase = sra_pkg::ph_skip;
					end
				end
				sra_pkg::ph_addr: begin
					next_st.addr = rx_byte;
					next_st.idx = 2'h0;
					if (st.word[0]) begin
						next_st.phase = sra_pkg::ph_wdata;
						next_st.tx_word = 32'h00000000;
						if (rx_byte == sra_pkg::addr_fw_query) begin
							next_st.tx_word = fw_revision;
						end
					end else begin
						next_st.phase = sra_pkg::ph_rdata;
						next_st.tx_word = 32'h00000000;
						next_st.rd_req = 1'b1;
					end
				end
				sra_pkg::ph_rdata: begin
					next_st.idx = st.idx + 2'h1;
					if (st.idx == sra_pkg::last_byte) begin
						next_st.addr = rx_byte;
						next_st.tx_word = 32'h00000000;
						next_st.rd_req = 1'b1;
					end
				end
				sra_pkg::ph_wdata: begin
					next_st.word = wr_word;
					next_st.idx = st.idx + 2'h1;
					if (st.idx == sra_pkg::last_byte) begin
						next_st.phase = sra_pkg::ph_skip;
						next_st.pend = 1'b1;
						next_st.pend_entry[40] = 1'b0;
						next_st.pend_entry[39:32] = st.addr;
						next_st.pend_entry[31:0] = wr_word;
						// zero data to command address runs command
						if (st.addr >= sra_pkg::addr_cmd_first && wr_word == 32'h00000000) begin
							next_st.pend_entry[40] = 1'b1;
							next_st.gyro = (st.addr == sra_pkg::addr_gyro_zero);
						end
					end
				end
				sra_pkg::ph_skip: begin
					next_st.phase = sra_pkg::ph_skip;
				end
				default: begin
					next_st.phase = sra_pkg::ph_op;
				end
			endcase
		end
		if (st.ss_n_f) begin
			next_st.miso = 1'b0;
			next_st.phase = sra_pkg::ph_op;
			next_st.bitcnt = 3'h0;
			next_st.idx = 2'h0;
		end
	end
	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.sck_s <= 3'h0;
			st.ss_s <= 3'h7;
			st.mosi_s <= 3'h7;
			st.ss_n_f <= 1'b1;
			st.mosi_f <= 1'b1;
			st.phase <= sra_pkg::ph_op;
		end else begin
			st <= next_st;
		end
	end
	assign miso = st.miso;
	assign miso_oe = st.miso_oe;
	assign rd_req = st.rd_req;
	assign rd_addr = st.addr;
	assign wr_cmd = buf_out[40];
	assign wr_addr = buf_out[39:32];
	assign wr_data = buf_out[31:0];
	assign gyro_zero_start = st.gyro;
endmodule : sra_slave

/* File: sra_pkg.sv */
// sra_pkg: constants and types for the serial register access slave
// assumes a 250 MHz core clock and a mode 0 serial master outside
package sra_pkg;
	// ----------------------------------------
	// operation codes and special addresses
	// ----------------------------------------
	localparam logic [7:0] op_read = 8'h00;
	localparam logic [7:0] op_write = 8'h01;
	localparam logic [7:0] addr_fw_query = 8'haa;
	localparam logic [7:0] addr_gyro_zero = 8'hac;
	localparam logic [7:0] addr_cmd_first = 8'haa;
	// ----------------------------------------
	// framing
	// ----------------------------------------
	localparam logic [2:0] last_bit = 3'h7;
	localparam logic [1:0] last_byte = 2'h3;
	localparam int entry_width = 41;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int clk_period_ps = 4000;
	localparam int sck_period_min_ps = 100000;
	localparam int byte_gap_min_ps = 5000000;
	localparam int sck_period_min_cycles = (sck_period_min_ps + clk_period_ps - 1) / clk_period_ps;
	localparam int byte_gap_min_cycles = (byte_gap_min_ps + clk_period_ps - 1) / clk_period_ps;
	// ----------------------------------------
	// transaction phases
	// ----------------------------------------
	typedef enum logic [4:0] {
		ph_op = 5'h01,
		ph_addr = 5'h02,
		ph_rdata = 5'h04,
		ph_wdata = 5'h08,
		ph_skip = 5'h10
	} sra_phase_type;
endpackage : sra_pkg

/* File: sra_buffer.sv */
// sra_buffer: two-entry buffer with valid and ready on both sides
// assumes both sides on core_clk; outputs come from flip-flops
`timescale 1ns/1ps
module sra_buffer #(
	parameter int width = 41
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	typedef struct packed {
		logic [width-1:0] head;
		logic head_valid;
		logic [width-1:0] tail;
		logic tail_valid;
	} sra_buf_type;
	sra_buf_type st;
	sra_buf_type next_st;
	logic push;
	logic pop;
	always_comb begin
		next_st = st;
		push = in_valid && !st.tail_valid;
		pop = st.head_valid && out_ready;
		if (pop || !st.head_valid) begin
			if (st.tail_valid) begin
				next_st.head = st.tail;
				next_st.head_valid = 1'b1;
				next_st.tail_valid = 1'b0;
			end else begin
				next_st.head = in_data;
				next_st.head_valid = push;
			end
		end else if (push) begin
			next_st.tail = in_data;
			next_st.tail_valid = 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign in_ready = !st.tail_valid;
	assign out_valid = st.head_valid;
	assign out_data = st.head;
endmodule : sra_buffer

/* File: sra_props.sv */
// sra_props: port assertions for sra_slave
// assumes a bind onto sra_slave
`timescale 1ns/1ps
module sra_props (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic rd_req,
	input wire logic [7:0] rd_addr,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic [31:0] fw_revision,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic wr_cmd,
	input wire logic [7:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic gyro_zero_start
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	rdreq_pulse_a: assert property (rd_req |=> !rd_req)
		else $error("rd_req held too long");
	req_selected_a: assert property (rd_req || gyro_zero_start |-> miso_oe)
		else $error("activity while deselected");
	gyro_pulse_a: assert property (gyro_zero_start |=> !gyro_zero_start)
		else $error("gyro start held too long");
	oe_select_a: assert property ((!ss_n) [*8] |-> miso_oe)
		else $error("miso not enabled while selected");
	oe_idle_a: assert property (ss_n [*8] |-> !miso_oe)
		else $error("miso enabled while deselected");
	miso_idle_a: assert property (!miso_oe |-> !miso)
		else $error("miso high while disabled");
	cmd_entry_a: assert property (wr_valid && wr_cmd |-> wr_data == 32'h0 && wr_addr >= 8'haa)
		else $error("bad command entry");
	wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_addr))
		else $error("entry changed while stalled");
endmodule : sra_props

/* File: sra_master.sv */
// sra_master: mode 0 serial master model
// assumes core_clk from the bench; link period 40 core cycles
`timescale 1ns/1ps
module sra_master (
	input wire logic core_clk,
	input wire logic miso,
	output logic sck,
	output logic ss_n,
	output logic mosi
);
	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b1;
	end
	task automatic frame(input logic sel);
		ss_n <= ~sel;
		mosi <= 1'b1;
		repeat (10) @(posedge core_clk);
	endtask : frame
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'b0;
			mosi <= tx[i];
			repeat (20) @(posedge core_clk);
			rx[i] = miso;
			sck <= 1'b1;
			repeat (20) @(posedge core_clk);
		end
		sck <= 1'b0;
		repeat (1250) @(posedge core_clk);
	endtask : xfer
endmodule : sra_master

/* File: tb_top.sv */
// tb_top: scenarios for sra_slave against sra_master
// assumes the bench plays register file and write consumer
`timescale 1ns/1ps
module tb_top;
	// arbitrary value
	localparam logic [31:0] rev = 32'h5e17a0c3;
	logic core_clk = 1'b0, arst_n = 1'b0, tog = 1'b0, rd_valid = 1'b0, wr_ready = 1'b0;
	logic sck, ss_n, mosi, miso, miso_oe, rd_req, wr_valid, wr_cmd, gyro_zero_start;
	logic [7:0] rd_addr, wr_addr, rx;
	logic [31:0] rd_data = 32'h0, wr_data, fw_rev = 32'h0;
	int failures = 0, checks = 0, cycles = 0, gyros = 0, reqs = 0;
	sra_slave uut (.core_clk(core_clk), .arst_n(arst_n), .sck(sck), .ss_n(ss_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_valid(rd_valid), .rd_data(rd_data), .fw_revision(fw_rev), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_cmd(wr_cmd), .wr_addr(wr_addr), .wr_data(wr_data),
		.gyro_zero_start(gyro_zero_start));
	sra_master m (.core_clk(core_clk), .miso(miso_oe ? miso : tog), .sck(sck), .ss_n(ss_n),
		.mosi(mosi));
	function automatic logic [31:0] word(input logic [7:0] a);
		return {a, ~a, a ^ 8'h5a, 8'hc3};
	endfunction : word
	initial forever #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		tog <= ~tog;
		rd_valid <= rd_req;
		rd_data <= word(rd_addr);
		cycles <= cycles + 1;
		gyros <= gyros + (gyro_zero_start === 1'b1);
		reqs <= reqs + (rd_req === 1'b1);
		if (cycles == 90000) begin
			failures = failures + 1;
			close_out();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic send4(input logic [31:0] tx, input logic [31:0] exp);
		for (int i = 3; i >= 0; i--) begin
			m.xfer(tx[8*i+:8], rx);
			check("miso byte", {24'h0, rx}, {24'h0, exp[8*i+:8]});
		end
	endtask : send4
	task automatic hdr(input logic [7:0] op, input logic [7:0] a);
		m.frame(1'b1);
		m.xfer(op, rx);
		m.xfer(a, rx);
	endtask : hdr
	task automatic pop(input logic [7:0] a, input logic [31:0] d, input logic c);
		check("wr_valid", wr_valid, 1);
		check("wr_addr", wr_addr, a);
		check("wr_data", wr_data, d);
		check("wr_cmd", wr_cmd, c);
		wr_ready <= 1'b1;
		@(posedge core_clk);
		wr_ready <= 1'b0;
		@(posedge core_clk);
	endtask : pop
	task automatic t_desel();
		m.xfer(8'h01, rx);
		check("miso_oe", miso_oe, 0);
		check("rd_req count", reqs, 0);
		m.frame(1'b1);
		m.xfer(8'h5a, rx);
		m.xfer(8'h10, rx);
		m.frame(1'b0);
		check("rd_req count", reqs, 0);
		check("wr_valid", wr_valid, 0);
	endtask : t_desel
	task automatic t_read();
		m.frame(1'b1);
		m.xfer(sra_pkg::op_write, rx);
		m.frame(1'b0);
		hdr(sra_pkg::op_read, 8'h10);
		check("rd_addr", {24'h0, rd_addr}, 32'h10);
		send4(32'h22, word(8'h10));
		send4(32'h0, word(8'h22));
		m.frame(1'b0);
	endtask : t_read
	task automatic t_write();
		hdr(sra_pkg::op_write, 8'h05);
		send4(32'h8badf00d, 32'h0);
		m.xfer(8'h77, rx);
		m.xfer(8'h66, rx);
		m.frame(1'b0);
		hdr(sra_pkg::op_write, 8'h06);
		send4(32'h01020304, 32'h0);
		m.frame(1'b0);
		pop(8'h05, 32'h8badf00d, 1'b0);
		pop(8'h06, 32'h01020304, 1'b0);
		check("wr_valid", wr_valid, 0);
	endtask : t_write
	task automatic t_cmd();
		hdr(sra_pkg::op_write, sra_pkg::addr_fw_query);
		send4(32'h0, rev);
		m.frame(1'b0);
		pop(sra_pkg::addr_fw_query, 32'h0, 1'b1);
		fw_rev <= ~rev;
		hdr(sra_pkg::op_write, sra_pkg::addr_fw_query);
		send4(32'h0, ~rev);
		m.frame(1'b0);
		pop(sra_pkg::addr_fw_query, 32'h0, 1'b1);
		hdr(sra_pkg::op_write, sra_pkg::addr_gyro_zero);
		send4(32'h0, 32'h0);
		m.frame(1'b0);
		check("gyro pulses", gyros, 1);
		pop(sra_pkg::addr_gyro_zero, 32'h0, 1'b1);
		hdr(sra_pkg::op_write, sra_pkg::addr_gyro_zero);
		send4(32'h00000100, 32'h0);
		m.frame(1'b0);
		check("gyro pulses", gyros, 1);
		pop(sra_pkg::addr_gyro_zero, 32'h00000100, 1'b0);
	endtask : t_cmd
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		fw_rev <= rev;
		repeat (10) @(posedge core_clk);
		t_desel();
		t_read();
		t_write();
		t_cmd();
		close_out();
	end
endmodule : tb_top
bind sra_slave sra_props chk (.*);
